// ---- rtl/irq_enable_bank.sv ----
// Bank of software-written interrupt enable words reached over APB.
// Assumes requests arrive as levels from logic on pclk; flags and priority lie downstream.
//
// What this block does
// - Enable one passes request, zero blocks it.
// - Word3 bit3 timer seven, bit0 timer six.
// - Word3 bit2 I2C2 master, bit1 slave.
// - Word5 bits3..1 UART3 tx/rx/error; bit0 unused.
// - Word7 bits15..6 unused; bits5..0 UART/debug.
`timescale 1ns/10ps

module irq_enable_bank
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [irq_enable_pkg::ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [irq_enable_pkg::SRC_W-1:0] irq_request_in,
    output logic [irq_enable_pkg::SRC_W-1:0] irq_request_out
);
    import irq_enable_pkg::*;

    // ------------------------------------------------------------------
    // Bus decode.
    // ------------------------------------------------------------------
    logic setup_phase;                       // First cycle of an APB transfer.
    logic access_done;                       // Edge at which the transfer completes.
    logic [NUM_WORDS-1:0] word_hit;          // One-hot address match.
    logic any_hit;                           // Address falls on a register.
    logic [SRC_W-1:0] enable_all;            // All enable words side by side.
    logic [WORD_W-1:0] read_word;            // Word selected for a read.

    assign setup_phase = psel && !penable;
    assign access_done = psel && penable && pready;
    assign any_hit = |word_hit;

    // ------------------------------------------------------------------
    // Enable words, one per generate slot.
    // ------------------------------------------------------------------
    genvar gi;
    generate
        for (gi = 0; gi < NUM_WORDS; gi++)
        begin : g_word
            logic [WORD_W-1:0] en_reg;       // Stored enables of this word.
            logic [WORD_W-1:0] en_next;      // Next value of the word.
            logic [WORD_W-1:0] gated_reg;    // Gated requests of this word.
            logic [WORD_W-1:0] gated_next;   // Next gated requests.
            localparam logic [WORD_W-1:0] MASK = IMPL_MASK[gi*WORD_W +: WORD_W];
            localparam logic [ADDR_W-1:0] OFFS =
                ADDR_W'(WORD_BASE + WORD_STRIDE * ADDR_W'(gi));

            assign word_hit[gi] = (paddr == OFFS);
            assign enable_all[gi*WORD_W +: WORD_W] = en_reg;

            // A write lands only on the completing edge; unused bits are masked away.
            always_comb
            begin
                en_next = en_reg;
                if (access_done && pwrite && word_hit[gi])
                begin
                    en_next = pwdata[WORD_W-1:0] & MASK;
                end
                // Each request passes only where its enable bit is one.
                gated_next = irq_request_in[gi*WORD_W +: WORD_W] & en_reg;
            end

            // Enables start masked so nothing reaches the CPU before software opts in.
            always_ff @(posedge pclk or negedge presetn)
            begin
                if (!presetn)
                begin
                    en_reg <= WORD_RESET;
                    gated_reg <= WORD_RESET;
                end
                else
                begin
                    en_reg <= en_next;
                    gated_reg <= gated_next;
                end
            end

            assign irq_request_out[gi*WORD_W +: WORD_W] = gated_reg;
        end
    endgenerate

    // ------------------------------------------------------------------
    // Read multiplexer.
    // ------------------------------------------------------------------
    // Stored bits are already masked, so unused positions read back as zero.
    always_comb
    begin
        read_word = WORD_RESET;
        for (int i = 0; i < NUM_WORDS; i++)
        begin
            if (word_hit[i])
            begin
                read_word = enable_all[i*WORD_W +: WORD_W];
            end
        end
    end

    // ------------------------------------------------------------------
    // APB answer: zero wait states, data captured in the setup cycle.
    // ------------------------------------------------------------------
    logic [31:0] prdata_reg;                 // Read data presented in the access cycle.
    logic [31:0] prdata_next;
    logic pready_reg;                        // High for exactly the access cycle.
    logic pready_next;
    logic pslverr_reg;                       // Error for an unmapped address.
    logic pslverr_next;

    // Registering the answer keeps outputs glitch-free and still answers every read with no wait state.
    always_comb
    begin
        pready_next = setup_phase;
        pslverr_next = setup_phase && !any_hit;
        prdata_next = prdata_reg;
        if (setup_phase)
        begin
            prdata_next = (pwrite || !any_hit) ? 32'h0000_0000 : {16'h0000, read_word};
        end
    end

    // Answer registers.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prdata_reg <= 32'h0000_0000;
            pready_reg <= 1'b0;
            pslverr_reg <= 1'b0;
        end
        else
        begin
            prdata_reg <= prdata_next;
            pready_reg <= pready_next;
            pslverr_reg <= pslverr_next;
        end
    end

    assign prdata = prdata_reg;
    assign pready = pready_reg;
    assign pslverr = pslverr_reg;

    // ------------------------------------------------------------------
    // Checks.
    // ------------------------------------------------------------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    // A completing write to a given word.
    sequence wr_word(int slot);
        access_done && pwrite && word_hit[slot];
    endsequence

    gate_pass_a: assert property (
        ##1 irq_request_out == ($past(irq_request_in) & $past(enable_all)))
        else $error("Gated request does not follow request and enable.");

    unused_zero_a: assert property (
        (enable_all & ~IMPL_MASK) == '0 && !(pready && !pwrite && prdata[31:WORD_W] != '0))
        else $error("Unused enable bit holds or reads a one.");

    timer_bits_a: assert property (
        wr_word(SLOT_WORD3) |=>
        enable_all[SLOT_WORD3*WORD_W + CCP_TIMER_SEVEN_BIT] == $past(pwdata[CCP_TIMER_SEVEN_BIT])
        && enable_all[SLOT_WORD3*WORD_W + CCP_TIMER_SIX_BIT] == $past(pwdata[CCP_TIMER_SIX_BIT]))
        else $error("Timer enables in word 3 not written.");

    i2c_bits_a: assert property (
        wr_word(SLOT_WORD3) |=> enable_all[SLOT_WORD3*WORD_W + I2C_PORT2_MASTER_EVENT_BIT]
        == $past(pwdata[I2C_PORT2_MASTER_EVENT_BIT])
        && enable_all[SLOT_WORD3*WORD_W + I2C_PORT2_SLAVE_EVENT_BIT]
        == $past(pwdata[I2C_PORT2_SLAVE_EVENT_BIT]))
        else $error("I2C enables in word 3 not written.");

    uart3_bits_a: assert property (
        wr_word(SLOT_WORD5) |=>
        enable_all[SLOT_WORD5*WORD_W + UART_THREE_TRANSMIT_BIT -: 3] == $past(pwdata[3:1])
        && !enable_all[SLOT_WORD5*WORD_W + WORD5_UNUSED_BIT])
        else $error("UART3 enables in word 5 wrong.");

    word7_bits_a: assert property (
        wr_word(SLOT_WORD7) |=>
        enable_all[SLOT_WORD7*WORD_W +: WORD_W] == {10'h000, $past(pwdata[WORD7_USED_TOP:0])}
        && enable_all[SLOT_WORD7*WORD_W + UART_FIVE_TRANSMIT_BIT]
        == $past(pwdata[UART_FIVE_TRANSMIT_BIT]))
        else $error("Word 7 enables wrong after write.");

    reset_clear_a: assert property (@(posedge pclk) disable iff (1'b0)
        !presetn |-> enable_all == '0 && irq_request_out == '0)
        else $error("Enables not clear during reset.");

    hold_idle_a: assert property (
        !(psel && penable && pwrite) [*2] |-> $stable(enable_all))
        else $error("Enables changed without a write.");

    answer_time_a: assert property (
        setup_phase |=> pready && pslverr == !$past(any_hit) ##1 !pready || setup_phase)
        else $error("APB answer not in the access cycle.");

    // A completing write whose address matches no word.
    sequence wr_miss;
        access_done && pwrite && !any_hit;
    endsequence

    // A refused write must leave every stored enable as it was.
    miss_write_a: assert property (
        wr_miss |=> $stable(enable_all))
        else $error("Write to an unmapped address changed an enable.");

    // The setup cycle of a read whose address matches a word.
    sequence rd_setup;
        setup_phase && !pwrite && any_hit;
    endsequence

    // Mapped reads are answered at once and never flagged as errors.
    read_ok_a: assert property (
        rd_setup |=> pready && !pslverr)
        else $error("Read of a mapped word not answered cleanly.");

endmodule

// ---- rtl/irq_enable_pkg.sv ----
// Constants for the interrupt enable bank: register offsets, masks and field positions.
// Assumes a 32-bit APB master and peripherals that present their requests on pclk.
package irq_enable_pkg;

    // ------------------------------------------------------------------
    // Geometry of the bank.
    // ------------------------------------------------------------------
    localparam int WORD_W = 16;              // Width of each enable word.
    localparam int NUM_WORDS = 5;            // Enable words 3 to 7.
    localparam int ADDR_W = 12;              // APB address width.
    localparam int SRC_W = WORD_W * NUM_WORDS;

    // ------------------------------------------------------------------
    // Register map: word 3 at the base, one aligned word per register.
    // ------------------------------------------------------------------
    localparam logic [ADDR_W-1:0] WORD_BASE = 12'h000;
    localparam logic [ADDR_W-1:0] WORD_STRIDE = 12'h004;
    localparam logic [WORD_W-1:0] WORD_RESET = 16'h0000;

    // Implemented bits of each word, word 3 in the low slice.
    localparam logic [SRC_W-1:0] IMPL_MASK =
        {16'h003f, 16'he47f, 16'hfffe, 16'h63cf, 16'h000f};

    // Word slots inside the bank.
    localparam int SLOT_WORD3 = 0;
    localparam int SLOT_WORD5 = 2;
    localparam int SLOT_WORD7 = 4;

    // Named fields used by the checks.
    localparam int CCP_TIMER_SEVEN_BIT = 3;
    localparam int I2C_PORT2_MASTER_EVENT_BIT = 2;
    localparam int I2C_PORT2_SLAVE_EVENT_BIT = 1;
    localparam int CCP_TIMER_SIX_BIT = 0;
    localparam int UART_THREE_TRANSMIT_BIT = 3;
    localparam int UART_THREE_ERROR_BIT = 1;
    localparam int WORD5_UNUSED_BIT = 0;
    localparam int UART_FIVE_TRANSMIT_BIT = 0;
    localparam int WORD7_USED_TOP = 5;

endpackage

// ---- tb/irq_src_model.sv ----
// Model of the peripheral sources that feed request levels into the enable bank.
// Assumes the bench picks the pattern; all requests are levels in the pclk domain.
`timescale 1ns/10ps
module irq_src_model
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [79:0] pattern,
    output logic [79:0] irq_request_in
);
    // Every source raises exactly the request that the bench pattern gives it.
    // The request is a registered level, so it never changes on the sampling edge.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            irq_request_in <= 80'h0;
        else
            irq_request_in <= pattern;
    end
endmodule

// ---- tb/irq_enable_bank_tb_top.sv ----
// Self-checking bench for the interrupt enable bank.
// Assumes a zero-or-more wait APB slave and registered request gating.
`timescale 1ns/10ps
module irq_enable_bank_tb_top;
    import irq_enable_pkg::*;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [79:0] pattern, req_in, req_out;
    logic er;
    int n_mismatch = 0;
    int cmp_count = 0;
    // --------------------------------------------------------------
    // Design, source model and clock.
    // --------------------------------------------------------------
    irq_enable_bank u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .irq_request_in(req_in), .irq_request_out(req_out));
    irq_src_model u_src (.pclk(pclk), .presetn(presetn), .pattern(pattern),
        .irq_request_in(req_in));
    initial
    begin
        pclk = 0;
        forever #12.5 pclk = ~pclk;
    end
    // --------------------------------------------------------------
    // Shared tasks.
    // --------------------------------------------------------------
    task automatic wrap_up();
        $display("mismatches %0d comparisons %0d", n_mismatch, cmp_count);
        if (n_mismatch == 0 && cmp_count > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    task automatic chk(input logic [79:0] got, input logic [79:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // One APB transfer; the request is held until pready is sampled high.
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do
        begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n >= 50)
        begin
            n_mismatch++;
            $display("ERROR t=%0t got=%h exp=%h", $time, n, 50);
            wrap_up();
        end
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // Writes all five words, reads them back, then checks the gated requests.
    task automatic gate(input logic [79:0] v, input logic [79:0] exp);
        for (int k = 0; k < NUM_WORDS; k++)
            apb(1'b1, 12'(4 * k), {16'h0, v[k*16+:16]});
        for (int k = 0; k < NUM_WORDS; k++)
        begin
            apb(1'b0, 12'(4 * k), 32'h0);
            chk({48'h0, rd}, {64'h0, exp[k*16+:16]});
        end
        repeat (3) @(posedge pclk);
        #1 chk(req_out, exp);
    endtask
    // --------------------------------------------------------------
    // Scenarios.
    // --------------------------------------------------------------
    // Reads every word without writing it; all must be clear and every request masked.
    task automatic clear_check();
        for (int k = 0; k < NUM_WORDS; k++)
        begin
            apb(1'b0, 12'(4 * k), 32'h0);
            chk({48'h0, rd}, 80'h0);
        end
        #1 chk(req_out, 80'h0);
    endtask
    task automatic t_reset();
        clear_check();
    endtask
    task automatic t_unmapped();
        apb(1'b1, 12'h014, 32'hffff);
        chk({79'h0, er}, 80'h1);
        apb(1'b0, 12'h002, 32'h0);
        chk({47'h0, er, rd}, 80'h1_0000_0000);
        clear_check();
    endtask
    // Every enable open, then a mixed request pattern must pass bit for bit.
    task automatic t_requests();
        gate(IMPL_MASK, IMPL_MASK);
        @(posedge pclk);
        pattern <= 80'h00a5_f0f0_3c3c_5a5a_0006;
        repeat (3) @(posedge pclk);
        #1 chk(req_out, 80'h00a5_f0f0_3c3c_5a5a_0006 & IMPL_MASK);
        @(posedge pclk);
        pattern <= {80{1'b1}};
    endtask
    // Reset in mid-run must clear words that software had set.
    task automatic t_midreset();
        gate({80{1'b1}}, IMPL_MASK);
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        clear_check();
    endtask
    task automatic t_fields();
        gate({80{1'b1}}, {16'h003f, 16'he47f, 16'hfffe, 16'h63cf, 16'h000f});
        gate(80'h0009, 80'h0009);
        gate(80'h0006, 80'h0006);
        gate({48'h000f, 32'h0}, {48'h000e, 32'h0});
        gate({16'hffc1, 64'h0}, {16'h0001, 64'h0});
        gate(80'h0, 80'h0);
    endtask
    initial
    begin
        presetn = 1'b0;
        {psel, penable, pwrite, paddr, pwdata} = '0;
        pattern = {80{1'b1}};
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        t_unmapped();
        t_fields();
        t_requests();
        t_midreset();
        wrap_up();
    end
endmodule
